// ### design/mphi_defs.vh
`ifndef MPHI_DEFS_VH
`define MPHI_DEFS_VH

// register byte offsets on the apb bus
`define MPHI_OFF_CTRL     12'h000
`define MPHI_OFF_STAT     12'h004
`define MPHI_OFF_STAT2    12'h008
`define MPHI_OFF_DATA     12'h00C
`define MPHI_OFF_ANC      12'h010
`define MPHI_OFF_VOLL     12'h014
`define MPHI_OFF_VOLR     12'h018
`define MPHI_OFF_LOWG     12'h01C
`define MPHI_OFF_MIDG     12'h020
`define MPHI_OFF_HIGHG    12'h024
`define MPHI_OFF_CLKDIV   12'h028
`define MPHI_OFF_IEN      12'h02C

// control register fields and reset value
`define MPHI_CTRL_EN      7
`define MPHI_CTRL_BBST    6
`define MPHI_CTRL_CRCPLAY 5
`define MPHI_CTRL_RST     8'h3F

// status register fields
`define MPHI_ST_ANC       7
`define MPHI_ST_REQ       6
`define MPHI_ST_LAY       5
`define MPHI_ST_SYN       4
`define MPHI_ST_CRC       3
`define MPHI_ST_VER       0
`define MPHI_VER_RST      1'b1

// second status register fields
`define MPHI_ST2_FREQ     4
`define MPHI_ST2_BREQ     3

// interrupt enable register fields
`define MPHI_IEN_GLOBAL   7
`define MPHI_IEN_DEC      5

// first request after enable fills the whole input buffer
`define MPHI_FIRST_REQ    11'h400

// ancillary buffer depth
`define MPHI_ANC_DEPTH    16
`define MPHI_ANC_AW       4

`endif

// ### design/mphi_top.v
// The APB slave port and the placing of the registers were left to the implementer.
`include "mphi_defs.vh"

// Function
// - decoding starts only once a complete frame sits in the buffer
// - data request sets request flag and frame request flag
// - frame request flag high while frame requested, low otherwise
// - byte request flag toggles on each data register write
// - first request after enable asks for 1024 bytes
// - decoder clock is the core clock divided by five-bit divisor
// - separate five-bit left and right volume codes
// - three equalizer bands, each with its own gain register
// - each band gain is a five-bit code
// - bass boost bit adds low-frequency gain
// - unsupported layer sets the layer error flag
// - missing synchronization pattern sets the sync error flag
// - checksum mismatch sets flag; frame played or rejected per enable
// - version bit and two-bit rate code reported in status
// - ancillary bytes read singly; available flag tracks non-empty buffer
// - five interrupt sources each with own status flag
// - each source has its own mask bit in control
// - interrupt needs decoder enable bit and global enable
// - status read clears all flags except ancillary available
// - control bit 7 enables the decoder
// - control bit 5 set plays bad-checksum frames, clear skips them
// - set mask bit blocks its flag from the interrupt
// - control resets to 0x3F
module mphi_top
(
  input  wire        CORE_CLK,       // core clock, 20 mhz
  input  wire        RST,            // async reset, active high
  input  wire        PSEL,           // apb select
  input  wire        PENABLE,        // apb access phase
  input  wire        PWRITE,         // apb direction
  input  wire [11:0] PADDR,          // apb byte address
  input  wire [31:0] PWDATA,         // apb write data
  output reg  [31:0] PRDATA,         // apb read data
  output reg         PREADY,         // apb ready
  output reg         PSLVERR,        // apb error, unmapped address
  input  wire [10:0] ENG_REQ_BYTES,  // bytes the engine wants next
  input  wire        ENG_REQ_VALID,  // engine asks for more data, pulse
  input  wire        ENG_LAYER_ERR,  // unsupported layer seen, pulse
  input  wire        ENG_SYNC_ERR,   // no sync pattern found, pulse
  input  wire        ENG_CRC_ERR,    // checksum mismatch, pulse
  input  wire        ENG_HDR_VALID,  // header decoded, pulse
  input  wire        ENG_HDR_VER,    // header version bit
  input  wire [1:0]  ENG_HDR_RATE,   // header rate code
  input  wire        ENG_ANC_VALID,  // ancillary byte from engine, pulse
  input  wire [7:0]  ENG_ANC_BYTE,   // ancillary byte value
  output reg  [7:0]  DATA_BYTE,      // compressed byte to frame buffer
  output reg         DATA_VALID,     // compressed byte strobe
  output reg         FRAME_READY,    // whole frame held, decode may start
  output reg         FRAME_SKIP,     // reject current frame (bad checksum)
  output reg         DEC_ENABLE,     // decoder enable level
  output reg         BASS_BOOST,     // bass boost level
  output reg  [4:0]  VOL_LEFT,       // left volume code
  output reg  [4:0]  VOL_RIGHT,      // right volume code
  output reg  [4:0]  GAIN_LOW,       // low band gain code
  output reg  [4:0]  GAIN_MID,       // mid band gain code
  output reg  [4:0]  GAIN_HIGH,      // high band gain code
  output reg         DEC_CLK_OUT,    // divided decoder clock
  output reg         DEC_IRQ         // decoder interrupt request
);

  // ==========================================================
  // declarations
  reg  [7:0]  ctrl_ff;
  reg  [4:0]  vol_l_ff;
  reg  [4:0]  vol_r_ff;
  reg  [4:0]  gain_low_ff;
  reg  [4:0]  gain_mid_ff;
  reg  [4:0]  gain_high_ff;
  reg  [4:0]  clk_div_ff;
  reg  [7:0]  ien_ff;
  reg         req_flag_ff;
  reg         lay_flag_ff;
  reg         syn_flag_ff;
  reg         crc_flag_ff;
  reg         ver_ff;
  reg  [1:0]  rate_ff;
  reg         byte_req_ff;
  reg  [10:0] remain_ff;
  reg         en_q_ff;
  reg  [4:0]  div_cnt_ff;
  reg  [7:0]  anc_mem [0:`MPHI_ANC_DEPTH-1];
  reg  [`MPHI_ANC_AW-1:0] anc_wp_ff;
  reg  [`MPHI_ANC_AW-1:0] anc_rp_ff;
  reg  [`MPHI_ANC_AW:0]   anc_cnt_ff;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;
  wire        acc_pend;
  wire        acc_done;
  wire        wr_done;
  wire        rd_done;
  wire        data_wr;
  wire        anc_pop;
  wire        anc_push;
  wire        anc_avail;
  wire        stat_rd;
  wire        en_rise;
  wire [7:0]  stat_val;
  wire [7:0]  stat2_val;
  wire [4:0]  irq_src;

  // ==========================================================
  // address decode helper, used only for the error check
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `MPHI_OFF_IEN);
    end
  endfunction

  // ==========================================================
  // apb handshake: one wait cycle, read data registered first
  assign acc_pend = PSEL & PENABLE & ~PREADY;
  assign acc_done = PSEL & PENABLE & PREADY;
  assign wr_done  = acc_done & PWRITE & ~PSLVERR;
  assign rd_done  = acc_done & ~PWRITE & ~PSLVERR;
  assign data_wr  = wr_done & (PADDR == `MPHI_OFF_DATA);
  assign anc_pop  = rd_done & (PADDR == `MPHI_OFF_ANC) & anc_avail;
  assign stat_rd  = rd_done & (PADDR == `MPHI_OFF_STAT);

  assign anc_avail = (anc_cnt_ff != {(`MPHI_ANC_AW+1){1'b0}});
  // full buffer drops new bytes; engine should not overrun
  // count top bit alone marks a full buffer, avoids a wide compare
  assign anc_push  = ENG_ANC_VALID & ~anc_cnt_ff[`MPHI_ANC_AW];

  assign stat_val  = {anc_avail, req_flag_ff, lay_flag_ff, syn_flag_ff,
                      crc_flag_ff, rate_ff, ver_ff};
  assign stat2_val = {3'b000, (remain_ff != 11'h000), byte_req_ff, 3'b000};

  // read data mux, reserved bits zero
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = ~is_mapped(PADDR);
    case (PADDR)
      `MPHI_OFF_CTRL:   nxt_rdata[7:0] = ctrl_ff;
      `MPHI_OFF_STAT:   nxt_rdata[7:0] = stat_val;
      `MPHI_OFF_STAT2:  nxt_rdata[7:0] = stat2_val;
      `MPHI_OFF_ANC:    nxt_rdata[7:0] = anc_mem[anc_rp_ff];
      `MPHI_OFF_VOLL:   nxt_rdata[4:0] = vol_l_ff;
      `MPHI_OFF_VOLR:   nxt_rdata[4:0] = vol_r_ff;
      `MPHI_OFF_LOWG:   nxt_rdata[4:0] = gain_low_ff;
      `MPHI_OFF_MIDG:   nxt_rdata[4:0] = gain_mid_ff;
      `MPHI_OFF_HIGHG:  nxt_rdata[4:0] = gain_high_ff;
      `MPHI_OFF_CLKDIV: nxt_rdata[4:0] = clk_div_ff;
      `MPHI_OFF_IEN:    nxt_rdata[7:0] = ien_ff;
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // bus response registers
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= acc_pend;
      if (acc_pend)
      begin
        PSLVERR <= nxt_err;
        PRDATA  <= PWRITE ? 32'h0000_0000 : nxt_rdata;
      end
      else
      begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software-written registers
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_ff      <= `MPHI_CTRL_RST;
      vol_l_ff     <= 5'h00;
      vol_r_ff     <= 5'h00;
      gain_low_ff  <= 5'h00;
      gain_mid_ff  <= 5'h00;
      gain_high_ff <= 5'h00;
      clk_div_ff   <= 5'h00;
      ien_ff       <= 8'h00;
    end
    else if (wr_done)
    begin
      case (PADDR)
        `MPHI_OFF_CTRL:   ctrl_ff      <= PWDATA[7:0];
        `MPHI_OFF_VOLL:   vol_l_ff     <= PWDATA[4:0];
        `MPHI_OFF_VOLR:   vol_r_ff     <= PWDATA[4:0];
        `MPHI_OFF_LOWG:   gain_low_ff  <= PWDATA[4:0];
        `MPHI_OFF_MIDG:   gain_mid_ff  <= PWDATA[4:0];
        `MPHI_OFF_HIGHG:  gain_high_ff <= PWDATA[4:0];
        `MPHI_OFF_CLKDIV: clk_div_ff   <= PWDATA[4:0];
        `MPHI_OFF_IEN:    ien_ff       <= PWDATA[7:0];
        default:          ctrl_ff      <= ctrl_ff;
      endcase
    end
  end

  // ==========================================================
  // data request handshake
  assign en_rise = ctrl_ff[`MPHI_CTRL_EN] & ~en_q_ff;

  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      en_q_ff     <= 1'b0;
      remain_ff   <= 11'h000;
      byte_req_ff <= 1'b0;
      DATA_BYTE   <= 8'h00;
      DATA_VALID  <= 1'b0;
      FRAME_READY <= 1'b0;
    end
    else
    begin
      en_q_ff     <= ctrl_ff[`MPHI_CTRL_EN];
      DATA_VALID  <= 1'b0;
      FRAME_READY <= 1'b0;
      if (!ctrl_ff[`MPHI_CTRL_EN])
        remain_ff <= 11'h000;
      else if (en_rise)
        remain_ff <= `MPHI_FIRST_REQ;
      else if (ENG_REQ_VALID && remain_ff == 11'h000)
        remain_ff <= ENG_REQ_BYTES;
      else if (data_wr && remain_ff != 11'h000)
      begin
        remain_ff  <= remain_ff - 11'h001;
        DATA_BYTE  <= PWDATA[7:0];
        DATA_VALID <= 1'b1;
        // whole frame in, decode may start
        FRAME_READY <= (remain_ff == 11'h001);
      end
      if (data_wr)
        byte_req_ff <= ~byte_req_ff;
    end
  end

  // ==========================================================
  // sticky status flags; hardware set wins over read clear
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      req_flag_ff <= 1'b0;
      lay_flag_ff <= 1'b0;
      syn_flag_ff <= 1'b0;
      crc_flag_ff <= 1'b0;
      ver_ff      <= `MPHI_VER_RST;
      rate_ff     <= 2'b00;
      FRAME_SKIP  <= 1'b0;
    end
    else
    begin
      // clear only bits actually returned by the read
      if (stat_rd && PRDATA[`MPHI_ST_REQ])
        req_flag_ff <= 1'b0;
      if (stat_rd && PRDATA[`MPHI_ST_LAY])
        lay_flag_ff <= 1'b0;
      if (stat_rd && PRDATA[`MPHI_ST_SYN])
        syn_flag_ff <= 1'b0;
      if (stat_rd && PRDATA[`MPHI_ST_CRC])
        crc_flag_ff <= 1'b0;
      if (en_rise || (ENG_REQ_VALID && ctrl_ff[`MPHI_CTRL_EN] && remain_ff == 11'h000))
        req_flag_ff <= 1'b1;
      if (ENG_LAYER_ERR)
        lay_flag_ff <= 1'b1;
      if (ENG_SYNC_ERR)
        syn_flag_ff <= 1'b1;
      // checksum error and play or reject
      if (ENG_CRC_ERR)
        crc_flag_ff <= 1'b1;
      if (ENG_CRC_ERR)
        FRAME_SKIP <= ~ctrl_ff[`MPHI_CTRL_CRCPLAY];
      else if (ENG_HDR_VALID)
        FRAME_SKIP <= 1'b0;
      if (ENG_HDR_VALID)
      begin
        ver_ff  <= ENG_HDR_VER;
        rate_ff <= ENG_HDR_RATE;
      end
    end
  end

  // ==========================================================
  // ancillary byte buffer
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      anc_wp_ff  <= {`MPHI_ANC_AW{1'b0}};
      anc_rp_ff  <= {`MPHI_ANC_AW{1'b0}};
      anc_cnt_ff <= {(`MPHI_ANC_AW+1){1'b0}};
    end
    else
    begin
      if (anc_push)
        anc_wp_ff <= anc_wp_ff + {{(`MPHI_ANC_AW-1){1'b0}}, 1'b1};
      if (anc_pop)
        anc_rp_ff <= anc_rp_ff + {{(`MPHI_ANC_AW-1){1'b0}}, 1'b1};
      if (anc_push && !anc_pop)
        anc_cnt_ff <= anc_cnt_ff + {{`MPHI_ANC_AW{1'b0}}, 1'b1};
      else if (anc_pop && !anc_push)
        anc_cnt_ff <= anc_cnt_ff - {{`MPHI_ANC_AW{1'b0}}, 1'b1};
    end
  end

  // buffer storage needs no reset
  always @(posedge CORE_CLK)
  begin
    if (anc_push)
      anc_mem[anc_wp_ff] <= ENG_ANC_BYTE;
  end

  // ==========================================================
  // decoder clock divider: divisor n gives core / (2 * (n + 1))
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      div_cnt_ff  <= 5'h00;
      DEC_CLK_OUT <= 1'b0;
    end
    else if (div_cnt_ff >= clk_div_ff)
    begin
      div_cnt_ff  <= 5'h00;
      DEC_CLK_OUT <= ~DEC_CLK_OUT;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
    end
  end

  // ==========================================================
  // interrupt combine and level outputs
  // five sources
  assign irq_src = {anc_avail, req_flag_ff, lay_flag_ff, syn_flag_ff, crc_flag_ff};

  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      DEC_IRQ    <= 1'b0;
      DEC_ENABLE <= 1'b0;
      BASS_BOOST <= 1'b0;
      VOL_LEFT   <= 5'h00;
      VOL_RIGHT  <= 5'h00;
      GAIN_LOW   <= 5'h00;
      GAIN_MID   <= 5'h00;
      GAIN_HIGH  <= 5'h00;
    end
    else
    begin
      // gated by decoder and global enables
      DEC_IRQ    <= (|(irq_src & ~ctrl_ff[4:0])) & ien_ff[`MPHI_IEN_DEC]
                    & ien_ff[`MPHI_IEN_GLOBAL];
      DEC_ENABLE <= ctrl_ff[`MPHI_CTRL_EN];
      BASS_BOOST <= ctrl_ff[`MPHI_CTRL_BBST];
      VOL_LEFT   <= vol_l_ff;
      VOL_RIGHT  <= vol_r_ff;
      GAIN_LOW   <= gain_low_ff;
      GAIN_MID   <= gain_mid_ff;
      GAIN_HIGH  <= gain_high_ff;
    end
  end

endmodule

// ### tb/mphi_chk.sv
module mphi_chk
(
  input logic        CORE_CLK,    // core clock
  input logic        RST,         // async reset
  input logic        PSEL,        // apb select
  input logic        PENABLE,     // apb access
  input logic        PWRITE,      // apb direction
  input logic [11:0] PADDR,       // apb address
  input logic [31:0] PWDATA,      // apb write data
  input logic        PREADY,      // apb ready
  input logic        PSLVERR,     // apb error
  input logic        ENG_CRC_ERR, // checksum pulse
  input logic [7:0]  DATA_BYTE,   // byte out
  input logic        DATA_VALID,  // byte strobe
  input logic        FRAME_READY, // frame complete
  input logic        FRAME_SKIP,  // frame reject
  input logic        DEC_ENABLE,  // enable level
  input logic        BASS_BOOST,  // boost level
  input logic [4:0]  VOL_LEFT     // left volume
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] pw1_ff;
  logic [31:0] pw2_ff;
  logic        dat_wr_ff;

  // ==========================
  // helper delays
  // outputs copy registers a cycle late, so keep old write data
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      pw1_ff <= '0;
      pw2_ff <= '0;
      dat_wr_ff <= 1'b0;
    end
    else
    begin
      pw1_ff <= PWDATA;
      pw2_ff <= pw1_ff;
      dat_wr_ff <= PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h00C;
    end

  // ==========================
  // properties
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // completed write to one address
  sequence s_wr(logic [11:0] a);
    PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
  endsequence

  a_ready_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (PREADY |-> PSLVERR == (PADDR > 12'h02C || PADDR[1:0] != 2'b00))
    else $error("error flag does not match address map");
  a_ctrl_out: assert property (s_wr(12'h000) |-> ##2 {DEC_ENABLE, BASS_BOOST} == pw2_ff[7:6])
    else $error("enable or boost level not taken from control");
  a_vol_out: assert property (s_wr(12'h014) |-> ##2 VOL_LEFT == pw2_ff[4:0])
    else $error("left volume not taken from register");
  a_data_fwd: assert property (DATA_VALID |-> dat_wr_ff && DATA_BYTE == pw1_ff[7:0])
    else $error("byte strobe without matching data write");
  a_frame_last: assert property (FRAME_READY |-> DATA_VALID)
    else $error("frame ready apart from a byte");
  a_skip_cause: assert property ($rose(FRAME_SKIP) |-> $past(ENG_CRC_ERR))
    else $error("frame skip without checksum error");
endmodule

bind mphi_top mphi_chk u_chk
(
  .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ENG_CRC_ERR(ENG_CRC_ERR), .DATA_BYTE(DATA_BYTE), .DATA_VALID(DATA_VALID),
  .FRAME_READY(FRAME_READY), .FRAME_SKIP(FRAME_SKIP), .DEC_ENABLE(DEC_ENABLE),
  .BASS_BOOST(BASS_BOOST), .VOL_LEFT(VOL_LEFT)
);

// ### tb/mphi_eng.sv
module mphi_eng
(
  input  logic        clk,         // core clock
  input  logic        rst,         // reset, active high
  input  logic [7:0]  data_byte,   // forwarded byte
  input  logic        data_valid,  // byte strobe
  input  logic        frame_ready, // frame complete
  output logic [10:0] req_bytes,   // bytes wanted
  output logic        req_valid,   // request pulse
  output logic        lay_err,     // layer error pulse
  output logic        syn_err,     // sync error pulse
  output logic        crc_err,     // checksum pulse
  output logic        hdr_valid,   // header pulse
  output logic        hdr_ver,     // header version
  output logic [1:0]  hdr_rate,    // header rate code
  output logic        anc_valid,   // ancillary pulse
  output logic [7:0]  anc_byte     // ancillary byte
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int frames;
  int bad;
  int need = 1024;

  // ==========================
  // byte sink
  // frame only after full buffer
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 0;
      frames <= 0;
      bad <= 0;
    end
    else if (data_valid)
    begin
      bad <= bad + int'(data_byte !== cnt[7:0]) + int'(frame_ready && cnt + 1 != need);
      frames <= frames + int'(frame_ready);
      cnt <= frame_ready ? 0 : cnt + 1;
    end

  // ==========================
  // event source
  initial
  begin
    {req_bytes, req_valid, lay_err, syn_err, crc_err} = '0;
    {hdr_valid, hdr_ver, hdr_rate, anc_valid, anc_byte} = '0;
  end

  // one event pulse; fields go stale so nothing leans on old values
  task automatic ev(input int k, input logic [10:0] v);
    @(posedge clk);
    case (k)
      0: {need, req_bytes, req_valid} <= {32'(v), v, 1'b1};
      1: lay_err <= 1'b1;
      2: syn_err <= 1'b1;
      3: crc_err <= 1'b1;
      4: {anc_byte, anc_valid} <= {v[7:0], 1'b1};
      default: {hdr_ver, hdr_rate, hdr_valid} <= {v[2:0], 1'b1};
    endcase
    @(posedge clk);
    {req_valid, lay_err, syn_err, crc_err, hdr_valid, anc_valid} <= '0;
    {req_bytes, anc_byte, hdr_ver, hdr_rate} <= ~{req_bytes, anc_byte, hdr_ver, hdr_rate};
  endtask
endmodule

// ### tb/mphi_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] rq_n;
  logic        rq_v, lay, syn, crc, hv, hver, av, dv, fr, skip, den, boost, dclk, irq;
  logic [1:0]  hrate;
  logic [7:0]  ab, db;
  logic [4:0]  vl, vr, gl, gm, gh;
  int          errors, total_checks, n, i, k, b;
  localparam int SB [5] = '{6, 5, 4, 3, 7};
  localparam int MB [5] = '{3, 2, 1, 0, 4};

  // ==========================
  // clock and parts
  always #25 clk = ~clk;

  mphi_top dut
  (
    .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ENG_REQ_BYTES(rq_n), .ENG_REQ_VALID(rq_v), .ENG_LAYER_ERR(lay), .ENG_SYNC_ERR(syn),
    .ENG_CRC_ERR(crc), .ENG_HDR_VALID(hv), .ENG_HDR_VER(hver), .ENG_HDR_RATE(hrate),
    .ENG_ANC_VALID(av), .ENG_ANC_BYTE(ab), .DATA_BYTE(db), .DATA_VALID(dv),
    .FRAME_READY(fr), .FRAME_SKIP(skip), .DEC_ENABLE(den), .BASS_BOOST(boost),
    .VOL_LEFT(vl), .VOL_RIGHT(vr), .GAIN_LOW(gl), .GAIN_MID(gm), .GAIN_HIGH(gh),
    .DEC_CLK_OUT(dclk), .DEC_IRQ(irq)
  );

  mphi_eng eng
  (
    .clk(clk), .rst(rst), .data_byte(db), .data_valid(dv), .frame_ready(fr),
    .req_bytes(rq_n), .req_valid(rq_v), .lay_err(lay), .syn_err(syn), .crc_err(crc),
    .hdr_valid(hv), .hdr_ver(hver), .hdr_rate(hrate), .anc_valid(av), .anc_byte(ab)
  );

  // ==========================
  // access tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t ns: got %h want %h", $time, g, e);
    end
  endtask

  // request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 16);
    {rd, er} = {prdata, pslverr};
    cmp(32'(t < 16), 32'h0000_0001);
    {psel, penable} <= 2'b00;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    cmp(rd, e);
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================
  // tests
  initial
  begin
    {clk, psel, penable, pwrite, paddr, pwdata, errors, total_checks} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h000, 32'h0000_003F);
    rdc(12'h004, 32'h0000_0001);
    rdc(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h030, 32'h0000_00FF);
    cmp(32'(er), 32'h0000_0001);
    $display("test reset done");
    apb(1'b1, 12'h02C, 32'h0000_00A0);
    apb(1'b1, 12'h000, 32'h0000_0080);
    repeat (3) @(posedge clk);
    cmp(32'({irq, den}), 32'h0000_0003);
    rdc(12'h004, 32'h0000_0041);
    rdc(12'h004, 32'h0000_0001);
    apb(1'b0, 12'h008, '0);
    cmp(rd & 32'h0000_0010, 32'h0000_0010);
    b = rd[3];
    for (i = 0; i < 1028; i++)
    begin
      apb(1'b1, 12'h00C, 32'(i % 1024 % 256));
      if (i < 2)
        rdc(12'h008, 32'h0000_0010 | 32'((b + i + 1) % 2 * 8));
      if (i == 1023)
        rdc(12'h008, 32'h0000_0000 | 32'((b + i + 1) % 2 * 8));
      if (i == 1023)
        eng.ev(0, 11'h004);
      if (i == 1023)
        rdc(12'h008, 32'h0000_0010);
    end
    // last byte strobe reaches the engine one cycle after the write lands
    repeat (2) @(posedge clk);
    cmp(eng.frames, 32'h0000_0002);
    cmp(eng.bad, 32'h0000_0000);
    $display("test stream done");
    apb(1'b0, 12'h004, '0);
    for (k = 0; k < 5; k++)
    begin
      apb(1'b1, 12'h000, 32'h0000_0080 | (32'h0000_0001 << MB[k]));
      eng.ev(k, 11'h0A5);
      repeat (3) @(posedge clk);
      cmp(32'(irq), 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0080);
      repeat (3) @(posedge clk);
      cmp(32'(irq), 32'h0000_0001);
      rdc(12'h004, (32'h0000_0001 << SB[k]) | 32'h0000_0001);
      repeat (3) @(posedge clk);
      cmp(32'(irq), 32'(k == 4));
    end
    cmp(32'(skip), 32'h0000_0001);
    eng.ev(4, 11'h03C);
    rdc(12'h010, 32'h0000_00A5);
    rdc(12'h004, 32'h0000_0081);
    rdc(12'h010, 32'h0000_003C);
    rdc(12'h004, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_00A0);
    eng.ev(3, 11'h000);
    apb(1'b1, 12'h02C, 32'h0000_0020);
    repeat (3) @(posedge clk);
    cmp(32'({skip, irq}), 32'h0000_0000);
    apb(1'b1, 12'h02C, 32'h0000_00A0);
    repeat (3) @(posedge clk);
    cmp(32'(irq), 32'h0000_0001);
    rdc(12'h004, 32'h0000_0009);
    $display("test interrupts done");
    for (i = 0; i < 8; i++)
    begin
      eng.ev(5, 11'(i));
      rdc(12'h004, 32'(i % 4 * 2 + i / 4));
    end
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, 12'(12'h014 + 4 * i), 32'hFFFF_FFE0 | 32'(31 - 7 * i));
      rdc(12'(12'h014 + 4 * i), 32'(31 - 7 * i));
      cmp(32'({vl, vr, gl, gm, gh} >> (20 - 5 * i)) & 32'h0000_001F, 32'(31 - 7 * i));
    end
    apb(1'b1, 12'h000, 32'h0000_00C0);
    repeat (3) @(posedge clk);
    cmp(32'(boost), 32'h0000_0001);
    $display("test controls done");
    apb(1'b1, 12'h028, 32'h0000_0002);
    repeat (2) @(dclk);
    b = dclk;
    n = 0;
    // three cycles per half period, seen on the fourth falling edge
    while (dclk === b && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    cmp(n, 32'h0000_0004);
    $display("test divider done");
    end_sim;
  end

  // hang guard, far beyond the roughly four and a half thousand cycles used
  initial
  begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule
